// [hdl/tmr_map.vh]
`ifndef TMR_MAP_VH
`define TMR_MAP_VH

// Register byte addresses on the Avalon slave
`define TMR_ADDR_W        5
`define TMR_OFS_CTRL0     5'h00
`define TMR_OFS_MODE      5'h04
`define TMR_OFS_IOC2      5'h08
`define TMR_OFS_CNT       5'h0c
`define TMR_OFS_CYC       5'h10
`define TMR_OFS_DUTY      5'h14
`define TMR_OFS_IRQ_STAT  5'h18
`define TMR_OFS_IRQ_MASK  5'h1c

// Field positions
`define TMR_CTRL0_RUN     0
`define TMR_MODE_LSB      0
`define TMR_MODE_MSB      2
`define TMR_MODE_SWTRIG   3
`define TMR_TRIG_LSB      0
`define TMR_TRIG_MSB      1
`define TMR_IRQ_CYC       0
`define TMR_IRQ_DUTY      1

// Mode encodings
`define TMR_MODE_ONESHOT  3'h3
`define TMR_MODE_PWM      3'h4

// Trigger edge encodings
`define TMR_EDGE_NONE     2'h0
`define TMR_EDGE_RISE     2'h1
`define TMR_EDGE_FALL     2'h2
`define TMR_EDGE_BOTH     2'h3

// Counter constants and reset values
`define TMR_CNT_MAX       16'hffff
`define TMR_CNT_ZERO      16'h0000
`define TMR_CNT_ONE       16'h0001
`define TMR_CMP_RST       16'h0000
`define TMR_IOC2_RST      8'h00
`define TMR_MODE_RST      3'h0
`define TMR_IRQ_RST       2'h0
`define TMR_RDATA_ZERO    32'h00000000

`endif

// [hdl/tmr_pwm.v]
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "tmr_map.vh"

module tmr_pwm (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        clk_en,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        trigger_pin,
    output reg         pwm_output_pin,
    output reg         toggle_output_pin,
    output wire        cycle_match_irq,
    output wire        duty_match_irq,
    output wire        irq
);

    // Software-visible registers
    reg        count_run_bit_r;
    reg [2:0]  mode_select_field_r;
    reg [7:0]  io_control_2_r;
    reg [15:0] cycle_compare_r;
    reg [15:0] duty_compare_r;
    reg [1:0]  irq_stat_r;
    reg [1:0]  irq_mask_r;

    // Counter core state
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [15:0] cycle_shadow_r;
    reg [15:0] duty_shadow_r;
    reg        running_r;
    reg        running_nxt;
    reg        pwm_nxt;
    reg        toggle_nxt;
    reg        load_shadow;
    reg        cyc_irq_r;
    reg        duty_irq_r;
    reg        cyc_evt;
    reg        duty_evt;

    // Bus slave state
    reg        ack_r;
    reg [31:0] rd_nxt;

    // Trigger synchroniser and edge detect
    reg        trig_meta_r;
    reg        trig_sync_r;
    reg        trig_prev_r;

    wire       bus_req;
    wire       wr_fire;
    wire       mode_oneshot;
    wire       mode_pwm;
    wire       sw_trig;
    wire       ext_trig;
    wire       trig_rise;
    wire       trig_fall;
    wire [1:0] trig_edge;
    wire [15:0] cyc_cmp;
    wire [15:0] duty_cmp;
    wire       cyc_hit;
    wire       duty_hit;
    wire       duty_comb;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;

    // One wait state: request taken at first edge, answered at the second
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_r;
    assign wr_fire         = avs_write & ack_r;

    assign mode_oneshot = (mode_select_field_r == `TMR_MODE_ONESHOT);
    assign mode_pwm     = (mode_select_field_r == `TMR_MODE_PWM);

    // Software trigger is a write of one to the trigger bit, never stored
    assign sw_trig = wr_fire && (avs_address == `TMR_OFS_MODE) && avs_writedata[`TMR_MODE_SWTRIG];

    // Edge detect reads only the second synchroniser stage
    assign trig_edge = io_control_2_r[`TMR_TRIG_MSB:`TMR_TRIG_LSB];
    assign trig_rise = trig_sync_r & ~trig_prev_r;
    assign trig_fall = ~trig_sync_r & trig_prev_r;
    assign ext_trig  = ((trig_edge == `TMR_EDGE_RISE) && trig_rise) ||
                       ((trig_edge == `TMR_EDGE_FALL) && trig_fall) ||
                       ((trig_edge == `TMR_EDGE_BOTH) && (trig_rise || trig_fall));

    // One-shot compares the live registers; PWM compares the shadows
    assign cyc_cmp  = mode_oneshot ? cycle_compare_r : cycle_shadow_r;
    assign duty_cmp = mode_oneshot ? duty_compare_r : duty_shadow_r;
    assign cyc_hit  = running_r && (count_r == cyc_cmp);
    assign duty_hit = running_r && (count_r == duty_cmp);

    // One-shot duty interrupt is combinational so it lines up with the pin edge
    assign duty_comb       = mode_oneshot && duty_hit;
    assign duty_match_irq  = duty_comb | duty_irq_r;
    assign cycle_match_irq = cyc_irq_r;

    // Two-flop synchroniser for the external trigger pin
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_meta_r <= 1'b0;
            trig_sync_r <= 1'b0;
            trig_prev_r <= 1'b0;
        end else if (clk_en) begin
            trig_meta_r <= trigger_pin;
            trig_sync_r <= trig_meta_r;
            trig_prev_r <= trig_sync_r;
        end
    end

    // Next-state logic of the counter, pins and events
    always @* begin
        count_nxt   = count_r;
        running_nxt = running_r;
        pwm_nxt     = pwm_output_pin;
        toggle_nxt  = toggle_output_pin;
        load_shadow = 1'b0;
        cyc_evt     = 1'b0;
        duty_evt    = 1'b0;
        if (!count_run_bit_r) begin
            // Stopped: idle at the maximum value, outputs inactive
            count_nxt   = `TMR_CNT_MAX;
            running_nxt = 1'b0;
            pwm_nxt     = 1'b0;
            toggle_nxt  = 1'b0;
        end else if (mode_pwm) begin
            if (!running_r) begin
                // Leaving idle: FFFFH becomes 0000H and shadows are primed
                count_nxt   = `TMR_CNT_ZERO;
                running_nxt = 1'b1;
                load_shadow = 1'b1;
                toggle_nxt  = 1'b1;
            end else if (cyc_hit) begin
                // Period is cycle value plus one count clocks
                count_nxt   = `TMR_CNT_ZERO;
                load_shadow = 1'b1;
                cyc_evt     = 1'b1;
                toggle_nxt  = ~toggle_output_pin;
            end else begin
                count_nxt   = count_r + `TMR_CNT_ONE;
            end
            // Duty interrupt is issued at the count-up after the match
            duty_evt = duty_hit;
            // Active while the next count is below the duty value
            if (load_shadow) begin
                pwm_nxt = (count_nxt < duty_compare_r);
            end else begin
                pwm_nxt = (count_nxt < duty_shadow_r);
            end
        end else if (mode_oneshot) begin
            if (!running_r) begin
                pwm_nxt    = 1'b0;
                toggle_nxt = 1'b0;
                count_nxt  = `TMR_CNT_MAX;
                if (ext_trig || sw_trig) begin
                    count_nxt   = `TMR_CNT_ZERO;
                    running_nxt = 1'b1;
                    toggle_nxt  = 1'b1;
                    pwm_nxt     = (duty_compare_r == `TMR_CNT_ZERO);
                end
            end else if (cyc_hit) begin
                // End of pulse: interrupt, pin inactive, counter parked
                count_nxt   = `TMR_CNT_MAX;
                running_nxt = 1'b0;
                pwm_nxt     = 1'b0;
                toggle_nxt  = 1'b0;
                cyc_evt     = 1'b1;
            end else begin
                // Plain increment wraps FFFFH to 0000H past a lowered compare
                count_nxt = count_r + `TMR_CNT_ONE;
                if (count_nxt == duty_compare_r) begin
                    pwm_nxt = 1'b1;
                end
            end
            // Triggers while running fall through untouched
        end else begin
            // Other modes are not served by this block
            count_nxt   = `TMR_CNT_MAX;
            running_nxt = 1'b0;
            pwm_nxt     = 1'b0;
            toggle_nxt  = 1'b0;
        end
    end

    // Counter, shadows, pins and registered interrupt pulses
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r           <= `TMR_CNT_MAX;
            running_r         <= 1'b0;
            cycle_shadow_r    <= `TMR_CMP_RST;
            duty_shadow_r     <= `TMR_CMP_RST;
            pwm_output_pin    <= 1'b0;
            toggle_output_pin <= 1'b0;
            cyc_irq_r         <= 1'b0;
            duty_irq_r        <= 1'b0;
        end else if (clk_en) begin
            count_r           <= count_nxt;
            running_r         <= running_nxt;
            pwm_output_pin    <= pwm_nxt;
            toggle_output_pin <= toggle_nxt;
            cyc_irq_r         <= cyc_evt;
            duty_irq_r        <= duty_evt;
            if (load_shadow) begin
                cycle_shadow_r <= cycle_compare_r;
                duty_shadow_r  <= duty_compare_r;
            end
        end
    end

    // Sticky status: a new event wins over a same-cycle write-one clear
    assign irq_set = {duty_match_irq, cycle_match_irq};
    assign irq_clr = (wr_fire && (avs_address == `TMR_OFS_IRQ_STAT)) ? avs_writedata[1:0] : 2'b00;
    assign irq     = |(irq_stat_r & irq_mask_r);

    // Register writes take effect at the edge the master sees waitrequest low
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_run_bit_r     <= 1'b0;
            mode_select_field_r <= `TMR_MODE_RST;
            io_control_2_r      <= `TMR_IOC2_RST;
            cycle_compare_r     <= `TMR_CMP_RST;
            duty_compare_r      <= `TMR_CMP_RST;
            irq_stat_r          <= `TMR_IRQ_RST;
            irq_mask_r          <= `TMR_IRQ_RST;
        end else if (clk_en) begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            if (wr_fire) begin
                case (avs_address)
                    `TMR_OFS_CTRL0: begin
                        count_run_bit_r <= avs_writedata[`TMR_CTRL0_RUN];
                    end
                    `TMR_OFS_MODE: begin
                        mode_select_field_r <= avs_writedata[`TMR_MODE_MSB:`TMR_MODE_LSB];
                    end
                    `TMR_OFS_IOC2: begin
                        // Stored as written; bits above the edge field are kept and read back but have no effect
                        io_control_2_r <= avs_writedata[7:0];
                    end
                    `TMR_OFS_CYC: begin
                        // Lowering while counting may wrap the counter
                        cycle_compare_r <= avs_writedata[15:0];
                    end
                    `TMR_OFS_DUTY: begin
                        duty_compare_r <= avs_writedata[15:0];
                    end
                    `TMR_OFS_IRQ_MASK: begin
                        irq_mask_r <= avs_writedata[1:0];
                    end
                    default: begin
                        irq_mask_r <= irq_mask_r;
                    end
                endcase
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero
    always @* begin
        rd_nxt = `TMR_RDATA_ZERO;
        case (avs_address)
            `TMR_OFS_CTRL0:    rd_nxt[`TMR_CTRL0_RUN] = count_run_bit_r;
            `TMR_OFS_MODE:     rd_nxt[`TMR_MODE_MSB:`TMR_MODE_LSB] = mode_select_field_r;
            `TMR_OFS_IOC2:     rd_nxt[7:0] = io_control_2_r;
            `TMR_OFS_CNT:      rd_nxt[15:0] = count_r;
            `TMR_OFS_CYC:      rd_nxt[15:0] = cycle_compare_r;
            `TMR_OFS_DUTY:     rd_nxt[15:0] = duty_compare_r;
            `TMR_OFS_IRQ_STAT: rd_nxt[1:0] = irq_stat_r;
            `TMR_OFS_IRQ_MASK: rd_nxt[1:0] = irq_mask_r;
            default:           rd_nxt = `TMR_RDATA_ZERO;
        endcase
    end

    // Acknowledge pulse and registered read data
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r        <= 1'b0;
            avs_readdata <= `TMR_RDATA_ZERO;
        end else if (clk_en) begin
            ack_r <= bus_req & ~ack_r;
            if (avs_read && !ack_r) begin
                avs_readdata <= rd_nxt;
            end
        end
    end

endmodule

// [bench/tmr_pwm_chk.sv]
`timescale 1ns/10ps
`include "tmr_map.vh"
module tmr_pwm_chk (
    input wire        clk,
    input wire        reset_n,
    input wire        clk_en,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        trigger_pin,
    input wire        pwm_output_pin,
    input wire        toggle_output_pin,
    input wire        cycle_match_irq,
    input wire        duty_match_irq,
    input wire        irq
);
    reg  [2:0] mode_r;
    wire       os_w = (mode_r == `TMR_MODE_ONESHOT);
    wire       pm_w = (mode_r == `TMR_MODE_PWM);
    // Mode copied from completed writes, since pin timing differs by mode
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            mode_r <= `TMR_MODE_RST;
        else if (clk_en && avs_write && !avs_waitrequest && avs_address == `TMR_OFS_MODE)
            mode_r <= avs_writedata[2:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_req; $rose(avs_read || avs_write); endsequence
    sequence s_ack; avs_waitrequest ##1 !avs_waitrequest; endsequence
    sequence s_fell; $past(pwm_output_pin, 2) && !$past(pwm_output_pin); endsequence
    a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_one_wait_state: assert property (s_req |-> s_ack)
        else $error("bus answer not after one wait state");
    a_upper_read_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_cycle_irq_pulse: assert property (cycle_match_irq |=> !cycle_match_irq)
        else $error("cycle irq longer than one cycle");
    a_os_duty_rise: assert property (os_w && duty_match_irq |-> $rose(pwm_output_pin))
        else $error("one-shot duty irq not with pin rise");
    a_os_cycle_stop: assert property (os_w && cycle_match_irq |-> !pwm_output_pin && !toggle_output_pin)
        else $error("one-shot end did not drop pins");
    a_pwm_toggle_flip: assert property (pm_w && cycle_match_irq |-> toggle_output_pin != $past(toggle_output_pin))
        else $error("toggle pin did not flip at clear");
    a_pwm_clear_high: assert property (pm_w && cycle_match_irq |-> pwm_output_pin)
        else $error("pwm pin not active at clear");
    a_pwm_duty_late: assert property (pm_w && duty_match_irq |-> s_fell)
        else $error("pwm duty irq not one cycle after match");
endmodule
bind tmr_pwm tmr_pwm_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_pin(trigger_pin), .pwm_output_pin(pwm_output_pin), .toggle_output_pin(toggle_output_pin),
    .cycle_match_irq(cycle_match_irq), .duty_match_irq(duty_match_irq), .irq(irq));

// [bench/tb_top.sv]
`timescale 1ns/10ps
`include "tmr_map.vh"
module tb_top;
    reg         clk, reset_n, clk_en, avs_read, avs_write, trigger_pin, pwm_q;
    reg  [4:0]  avs_address;
    reg  [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, pwm_output_pin, toggle_output_pin;
    wire        cycle_match_irq, duty_match_irq, irq;
    integer     n_errors, checks_done, cyc, seed, rise_t, c_val, d_val, i;
    reg  [31:0] exp_rd[$];
    integer     exp_w[$];
    integer     exp_p[$];

    tmr_pwm uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger_pin(trigger_pin),
        .pwm_output_pin(pwm_output_pin), .toggle_output_pin(toggle_output_pin),
        .cycle_match_irq(cycle_match_irq), .duty_match_irq(duty_match_irq), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task check_bits(input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: bits exp %h got %h", $time, e, g);
            end
        end
    endtask

    task check_num(input integer e, input integer g);
        begin
            checks_done = checks_done + 1;
            if (g != e) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: cycles exp %0d got %0d", $time, e, g);
            end
        end
    endtask

    task end_sim;
        begin
            $display("errors %0d checks %0d", n_errors, checks_done);
            if (n_errors == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // Waitrequest is looked at mid-cycle, where it is settled, so the release
    // always follows the rising edge at which the slave answered
    task bus_wr(input [4:0] a, input [31:0] d);
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= 1'b1;
            @(negedge clk);
            while (avs_waitrequest !== 1'b0) @(negedge clk);
            @(posedge clk);
            avs_write <= 1'b0;
            @(posedge clk);
        end
    endtask

    task bus_rd(input [4:0] a, input [31:0] e);
        begin
            exp_rd.push_back(e);
            avs_address <= a;
            avs_read <= 1'b1;
            @(negedge clk);
            while (avs_waitrequest !== 1'b0) @(negedge clk);
            @(posedge clk);
            avs_read <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Read data is compared mid-cycle, while it stands with waitrequest low
    always @(negedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_rd.size() > 0)
            check_bits(exp_rd.pop_front(), avs_readdata);
    end

    // Watcher: pulse widths and periods against the oldest note
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (pwm_output_pin === 1'b1 && !pwm_q) begin
            if (exp_p.size() > 0 && rise_t > 0)
                check_num(exp_p.pop_front(), cyc - rise_t);
            rise_t = cyc;
        end
        if (pwm_output_pin === 1'b0 && pwm_q && exp_w.size() > 0)
            check_num(exp_w.pop_front(), cyc - rise_t);
        pwm_q = (pwm_output_pin === 1'b1);
        if (cyc > 90000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end

    initial begin
        seed = 32'h37b81d99;
        n_errors = 0;
        checks_done = 0;
        cyc = 0;
        rise_t = 0;
        pwm_q = 1'b0;
        {reset_n, avs_read, avs_write, trigger_pin} = 4'h0;
        clk_en = 1'b1;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus_rd(`TMR_OFS_CNT, 32'h0000ffff);
        bus_rd(`TMR_OFS_DUTY, 32'h00000000);
        bus_wr(`TMR_OFS_IOC2, 32'h0000000c);
        bus_rd(`TMR_OFS_IOC2, 32'h0000000c);
        // PWM with random cycle and duty, duty lowered just after the start from idle
        c_val = 12 + ($random(seed) & 7);
        d_val = 5 + ($random(seed) & 3);
        bus_wr(`TMR_OFS_CYC, c_val);
        bus_rd(`TMR_OFS_CYC, c_val);
        bus_wr(`TMR_OFS_DUTY, d_val);
        bus_wr(`TMR_OFS_IRQ_MASK, 32'h00000001);
        bus_wr(`TMR_OFS_MODE, {29'h0, `TMR_MODE_PWM});
        exp_w.push_back(d_val);
        exp_p.push_back(c_val + 1);
        bus_wr(`TMR_OFS_CTRL0, 32'h00000001);
        for (i = 0; i < 50 && pwm_output_pin !== 1'b1; i = i + 1) @(posedge clk);
        bus_wr(`TMR_OFS_DUTY, 32'h00000002);
        exp_w.push_back(2);
        for (i = 0; i < 200 && exp_w.size() > 0; i = i + 1) @(posedge clk);
        bus_wr(`TMR_OFS_CTRL0, 32'h00000000);
        bus_rd(`TMR_OFS_IRQ_STAT, 32'h00000003);
        check_bits(32'h00000001, {31'h0, irq});
        bus_wr(`TMR_OFS_IRQ_STAT, 32'h00000001);
        bus_rd(`TMR_OFS_IRQ_STAT, 32'h00000002);
        check_bits(32'h00000000, {31'h0, irq});
        bus_wr(`TMR_OFS_IRQ_STAT, 32'h00000002);
        // One-shot by software, with a pin edge during the pulse that must do nothing
        bus_wr(`TMR_OFS_CYC, 32'h0000000c);
        bus_wr(`TMR_OFS_DUTY, 32'h00000004);
        bus_wr(`TMR_OFS_IOC2, 32'h00000001);
        bus_wr(`TMR_OFS_MODE, {29'h0, `TMR_MODE_ONESHOT});
        bus_wr(`TMR_OFS_CTRL0, 32'h00000001);
        exp_w.push_back(9);
        bus_wr(`TMR_OFS_MODE, {28'h0, 1'b1, `TMR_MODE_ONESHOT});
        trigger_pin <= 1'b1;
        for (i = 0; i < 100 && exp_w.size() > 0; i = i + 1) @(posedge clk);
        bus_rd(`TMR_OFS_CNT, 32'h0000ffff);
        // Pin edge starts the next pulse
        trigger_pin <= 1'b0;
        repeat (4) @(posedge clk);
        exp_w.push_back(9);
        trigger_pin <= 1'b1;
        for (i = 0; i < 100 && exp_w.size() > 0; i = i + 1) @(posedge clk);
        // Both compares lowered below the running count: full wrap, then pulse
        bus_wr(`TMR_OFS_CYC, 32'h00000028);
        bus_wr(`TMR_OFS_DUTY, 32'h0000001e);
        exp_w.push_back(6);
        bus_wr(`TMR_OFS_MODE, {28'h0, 1'b1, `TMR_MODE_ONESHOT});
        repeat (12) @(posedge clk);
        bus_wr(`TMR_OFS_DUTY, 32'h00000005);
        bus_wr(`TMR_OFS_CYC, 32'h0000000a);
        for (i = 0; i < 70000 && exp_w.size() > 0; i = i + 1) @(posedge clk);
        check_num(0, exp_w.size());
        end_sim;
    end
endmodule
